/* rtl/sbx_sys_bus_access.sv */
// Purpose: debugger system bus access registers and launch control
// Assumes: one debugger request per cycle, each answered one cycle later
// Notes: control bits are plain ports, their register lives elsewhere; status bits are registered in this block
// Notes on behaviour
// R1: address register, 32 bits, zero at reset, gives every access target.
// R2: read-on-address set: each address write launches a read there.
// R3: address-write read only when error field and busy-error both zero.
// R4: address write while busy sets busy-error and is dropped.
// R5: low data register holds data bits 31:0, zero at reset.
// R6: successful read loads both data registers; upper bits may be junk.
// R7: low data read returns contents; read-on-data also launches a read.
// R8: low data write launches a bus write of both data words.
// R9: upper data register never launches anything.
// R10: debugger touches upper word before lower word for wide data.
// R11: low data launches only when error field and busy-error are zero.
// R12: data register access while busy sets busy-error and is dropped.
// R13: high data register holds bits 63:32, zero at reset.
// R14: registers at word offsets 0x39, 0x3C, 0x3D of the debugger port.
// R15: auto-increment adds access size in bytes after each good access.
// R16: size 0..3 is 8..64 bits; larger sets error 4, no access.
// R17: busy set on request, held until access fully completes.
// R18: error 2 bad address, 3 misaligned, 4 size; cleared by writing ones.
// R19: one access outstanding; next accepted only after busy clears.
// R20: aborted access leaves registers unchanged and issues no bus traffic.
`timescale 1ns/1ps
module sbx_sys_bus_access (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // debugger register port
  input wire sbx_pkg::sbx_dmi_req_t dmi_req,
  output logic dmi_rsp_valid,
  output logic [31:0] dmi_rdata,
  // control settings
  input wire logic read_on_addr,
  input wire logic read_on_data,
  input wire logic auto_increment,
  input wire logic [2:0] access_size,
  // status and clears
  input wire logic error_wr,
  input wire logic [2:0] error_wdata,
  input wire logic busy_error_clr,
  output logic bus_busy,
  output logic busy_error,
  output logic [2:0] bus_error,
  // system bus
  output sbx_pkg::sbx_bus_req_t bus_req,
  input wire logic bus_ready,
  input wire sbx_pkg::sbx_bus_rsp_t bus_rsp
);

  // bytes moved by one access of the given size code
  function automatic logic [31:0] size_bytes(input logic [2:0] size);
    size_bytes = 32'h0000_0001 << size[1:0];
  endfunction

  logic [31:0] addr_q;
  logic [31:0] data_lo_q;
  logic [31:0] data_hi_q;
  logic [2:0] err_q;
  logic busy_err_q;
  logic rsp_valid_q;
  logic [31:0] rdata_q;
  logic done;
  logic done_err;
  logic [63:0] done_rdata;
  logic launch_wr_q;
  sbx_pkg::sbx_bus_req_t launch;

  // register decode
  wire hit_addr = dmi_req.valid && (dmi_req.addr == sbx_pkg::SBX_OFF_ADDR); // R14
  wire hit_lo = dmi_req.valid && (dmi_req.addr == sbx_pkg::SBX_OFF_DATA_LO); // R14
  wire hit_hi = dmi_req.valid && (dmi_req.addr == sbx_pkg::SBX_OFF_DATA_HI); // R14
  wire hit_any = hit_addr || hit_lo || hit_hi;
  wire abort = hit_any && bus_busy; // R4 R12
  wire take = hit_any && !bus_busy; // R20
  wire blocked = (err_q != sbx_pkg::SBX_ERR_NONE) || busy_err_q; // R3 R11

  // launch decode; the upper word never launches an access
  wire want_rd_addr = take && hit_addr && dmi_req.write && read_on_addr; // R2
  wire want_rd_data = take && hit_lo && !dmi_req.write && read_on_data; // R7
  wire want_wr = take && hit_lo && dmi_req.write; // R8 R9
  wire want = (want_rd_addr || want_rd_data || want_wr) && !blocked; // R3 R11
  wire size_bad = access_size > sbx_pkg::SBX_SIZE_MAX; // R16
  wire [31:0] tgt_addr = hit_addr ? dmi_req.wdata : addr_q;
  wire misalign = (tgt_addr & (size_bytes(access_size) - 32'h0000_0001)) != 32'h0;
  wire go = want && !size_bad && !misalign;
  wire err_clr = error_wr && (error_wdata == sbx_pkg::SBX_ERR_CLR_ALL); // R18

  // launch carries the fresh address or fresh low word of this same request
  assign launch.valid = go;
  assign launch.write = want_wr;
  assign launch.size = access_size;
  assign launch.addr = tgt_addr; // R1
  assign launch.wdata = {data_hi_q, hit_lo ? dmi_req.wdata : data_lo_q}; // R8

  // next error code; a new error wins over a clear in the same cycle
  wire [2:0] err_new = (want && size_bad) ? sbx_pkg::SBX_ERR_SIZE :
                       (want && misalign) ? sbx_pkg::SBX_ERR_ALIGN :
                       done_err ? sbx_pkg::SBX_ERR_BADADDR : sbx_pkg::SBX_ERR_NONE; // R16 R18
  wire [2:0] err_d = (err_new != sbx_pkg::SBX_ERR_NONE) ? err_new :
                     err_clr ? sbx_pkg::SBX_ERR_NONE : err_q; // R18
  wire good_done = done && !done_err;
  wire [31:0] addr_inc = addr_q + size_bytes(access_size); // R15

  sbx_bus_master u_master (
    .clk(clk),
    .rst_b(rst_b),
    .launch(launch),
    .busy(bus_busy),
    .done(done),
    .done_err(done_err),
    .done_rdata(done_rdata),
    .bus_req(bus_req),
    .bus_ready(bus_ready),
    .bus_rsp(bus_rsp)
  );

  assign busy_error = busy_err_q;
  assign bus_error = err_q;
  assign dmi_rsp_valid = rsp_valid_q;
  assign dmi_rdata = rdata_q;

  // address register: debugger write or auto-increment, never both at once
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      addr_q <= sbx_pkg::SBX_RST_WORD; // R1
    else if (take && hit_addr && dmi_req.write)
      addr_q <= dmi_req.wdata; // R1
    else if (good_done && auto_increment)
      addr_q <= addr_inc; // R15
  end

  // direction of the access in flight; the bus request is already gone when it answers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      launch_wr_q <= 1'b0;
    else if (go)
      launch_wr_q <= want_wr; // R6
  end

  // data registers; completions only happen while busy, so no write collides
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      data_lo_q <= sbx_pkg::SBX_RST_WORD; // R5
      data_hi_q <= sbx_pkg::SBX_RST_WORD; // R13
    end
    else if (good_done && !launch_wr_q)
    begin
      data_lo_q <= done_rdata[31:0]; // R6
      data_hi_q <= done_rdata[63:32]; // R6
    end
    else if (take && dmi_req.write)
    begin
      if (hit_lo) data_lo_q <= dmi_req.wdata; // R5
      if (hit_hi) data_hi_q <= dmi_req.wdata; // R13
    end
  end

  // status flags; setting beats clearing
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      err_q <= sbx_pkg::SBX_ERR_NONE;
      busy_err_q <= 1'b0;
    end
    else
    begin
      err_q <= err_d; // R18
      busy_err_q <= abort || (busy_err_q && !busy_error_clr); // R4 R12
    end
  end

  // debugger answer one cycle after each request; unmapped offsets read zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rsp_valid_q <= 1'b0;
      rdata_q <= sbx_pkg::SBX_RST_WORD;
    end
    else
    begin
      rsp_valid_q <= dmi_req.valid;
      rdata_q <= hit_addr ? addr_q : hit_lo ? data_lo_q : hit_hi ? data_hi_q : 32'h0000_0000; // R7
    end
  end

  // a debugger request that launches exactly one access
  sequence s_launch;
    go ##1 bus_busy;
  endsequence

  a_addr_write: assert property (@(posedge clk) disable iff (!rst_b)
    (take && hit_addr && dmi_req.write) |=> addr_q == $past(dmi_req.wdata)) // R1
    else $error("address write not stored");
  a_read_on_addr: assert property (@(posedge clk) disable iff (!rst_b)
    (want_rd_addr && !blocked && !size_bad && !misalign) |-> s_launch) // R2
    else $error("address write did not launch read");
  a_blocked_none: assert property (@(posedge clk) disable iff (!rst_b)
    blocked |-> !launch.valid) // R3 R11
    else $error("access launched while error pending");
  a_busy_abort: assert property (@(posedge clk) disable iff (!rst_b)
    (abort && !done) |=> busy_err_q && $stable(addr_q) && $stable(data_lo_q) && $stable(data_hi_q)) // R4 R12 R20
    else $error("busy access not aborted");
  a_read_load: assert property (@(posedge clk) disable iff (!rst_b)
    (good_done && !launch_wr_q) |=> {data_hi_q, data_lo_q} == $past(done_rdata)) // R6
    else $error("read data not loaded");
  a_write_start: assert property (@(posedge clk) disable iff (!rst_b)
    (go && want_wr) |-> s_launch) // R8
    else $error("low data write did not launch");
  a_high_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    hit_hi |-> !launch.valid) // R9
    else $error("upper word launched an access");
  a_auto_incr: assert property (@(posedge clk) disable iff (!rst_b)
    (good_done && auto_increment) |=> addr_q == $past(addr_q) + $past(size_bytes(access_size))) // R15
    else $error("address not incremented");
  a_bad_size: assert property (@(posedge clk) disable iff (!rst_b)
    (want && size_bad) |-> !launch.valid ##1 err_q == sbx_pkg::SBX_ERR_SIZE) // R16
    else $error("bad size not flagged");

endmodule

/* rtl/sbx_pkg.sv */
// Purpose: shared constants and carriers for the debug system bus access block
// Assumes: debug module interface word offsets of 7 bits, 32-bit system bus addresses
// Notes: error codes and size codes follow the control/status layout
package sbx_pkg;

  // debug module interface word offsets
  localparam logic [6:0] SBX_OFF_ADDR = 7'h39;
  localparam logic [6:0] SBX_OFF_DATA_LO = 7'h3c;
  localparam logic [6:0] SBX_OFF_DATA_HI = 7'h3d;

  // reset values
  localparam logic [31:0] SBX_RST_WORD = 32'h0000_0000;

  // error field codes
  localparam logic [2:0] SBX_ERR_NONE = 3'h0;
  localparam logic [2:0] SBX_ERR_BADADDR = 3'h2;
  localparam logic [2:0] SBX_ERR_ALIGN = 3'h3;
  localparam logic [2:0] SBX_ERR_SIZE = 3'h4;
  localparam logic [2:0] SBX_ERR_CLR_ALL = 3'h7;

  // largest supported size code (3 = 64-bit)
  localparam logic [2:0] SBX_SIZE_MAX = 3'h3;

  // debugger register request
  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] addr;
    logic [31:0] wdata;
  } sbx_dmi_req_t;

  // system bus request
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] size;
    logic [31:0] addr;
    logic [63:0] wdata;
  } sbx_bus_req_t;

  // system bus response
  typedef struct packed {
    logic valid;
    logic error;
    logic [63:0] rdata;
  } sbx_bus_rsp_t;

endpackage

/* rtl/sbx_bus_master.sv */
// Purpose: single-outstanding system bus master for debugger accesses
// Assumes: bus holds request until ready, answers once per request
// Notes: busy covers the whole access, from launch to response
`timescale 1ns/1ps
module sbx_bus_master (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // launch side
  input wire sbx_pkg::sbx_bus_req_t launch,
  output logic busy,
  output logic done,
  output logic done_err,
  output logic [63:0] done_rdata,
  // system bus side
  output sbx_pkg::sbx_bus_req_t bus_req,
  input wire logic bus_ready,
  input wire sbx_pkg::sbx_bus_rsp_t bus_rsp
);

  typedef enum logic [1:0] {
    SBX_ST_IDLE = 2'b00,
    SBX_ST_ISSUE = 2'b01,
    SBX_ST_WAIT = 2'b10
  } sbx_state_t;

  sbx_state_t state_q;
  sbx_state_t state_d;
  sbx_pkg::sbx_bus_req_t req_q;
  wire accept = launch.valid && (state_q == SBX_ST_IDLE);

  // state decode; new launches only taken when idle
  assign busy = (state_q != SBX_ST_IDLE); // R17
  assign done = (state_q == SBX_ST_WAIT) && bus_rsp.valid;
  assign done_err = done && bus_rsp.error;
  assign done_rdata = bus_rsp.rdata;
  assign bus_req = (state_q == SBX_ST_ISSUE) ? req_q : '0; // R19

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      SBX_ST_IDLE: if (launch.valid) state_d = SBX_ST_ISSUE;
      SBX_ST_ISSUE: if (bus_ready) state_d = SBX_ST_WAIT;
      SBX_ST_WAIT: if (bus_rsp.valid) state_d = SBX_ST_IDLE;
      default: state_d = SBX_ST_IDLE;
    endcase
  end

  // request is latched so it stays stable while the bus stalls
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q <= SBX_ST_IDLE;
      req_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (accept) req_q <= launch;
    end
  end

  // one access at a time: busy stays up until the response
  a_busy_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (accept || (busy && !done)) |=> busy) // R17
    else $error("busy dropped before response");
  // a launch offered while busy would be lost silently, so the parent must never offer one
  a_one_issue: assert property (@(posedge clk) disable iff (!rst_b)
    busy |-> !launch.valid) // R19
    else $error("second access offered while busy");

endmodule

/* tb/sbx_bus_model.sv */
// Purpose: system bus slave model facing the debugger bus master
// Assumes: one request outstanding, request held until ready
// Notes: slow stalls ready and answer; fail answers with an error
`timescale 1ns/1ps
module sbx_bus_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // test controls
  input wire logic slow,
  input wire logic fail,
  // system bus
  input wire sbx_pkg::sbx_bus_req_t bus_req,
  output logic bus_ready,
  output sbx_pkg::sbx_bus_rsp_t bus_rsp,
  // observation
  output sbx_pkg::sbx_bus_req_t last_req,
  output int n_acc
);
  logic pend;
  logic [2:0] dly;
  // accept, wait, answer; idle rdata flips so stale data never looks right
  always @(posedge clk)
  begin
    bus_ready <= 1'b0;
    bus_rsp.valid <= 1'b0;
    bus_rsp.rdata <= ~bus_rsp.rdata;
    if (!rst_b)
    begin
      pend <= 1'b0;
      dly <= 3'h0;
      n_acc <= 0;
      bus_rsp <= '0;
      last_req <= '0;
    end
    else if (pend)
    begin
      dly <= dly - 3'h1;
      if (dly == 3'h0)
      begin
        pend <= 1'b0;
        dly <= 3'h0;
        bus_rsp.valid <= 1'b1;
        bus_rsp.error <= fail;
        bus_rsp.rdata <= {~last_req.addr, last_req.addr};
      end
    end
    else if (bus_req.valid && bus_ready)
    begin
      pend <= 1'b1;
      dly <= slow ? 3'h3 : 3'h0;
      last_req <= bus_req;
      n_acc <= n_acc + 1;
    end
    else if (bus_req.valid)
    begin
      dly <= dly + 3'h1;
      bus_ready <= !slow || dly == 3'h3;
    end
  end
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for the debugger system bus access block
// Assumes: inputs driven at the falling edge, answers one cycle later
// Notes: table rows cover plain register access, hand tests the launches
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top;
  typedef struct packed {logic w; logic [6:0] a; logic [31:0] d;} sbx_row_t;
  logic clk, rst_b, rsp_v, roa, rod, ainc, ewr, bclr, busy, berr_busy, slow, fail, bus_ready;
  logic [2:0] size, ewd, berr;
  logic [31:0] rdata, r;
  sbx_pkg::sbx_dmi_req_t req;
  sbx_pkg::sbx_bus_req_t bus_req, last_req;
  sbx_pkg::sbx_bus_rsp_t bus_rsp;
  int n_acc, failures, n_checks, i, k;
  sbx_row_t rows [9] = '{{1'b0, 7'h39, 32'h0}, {1'b0, 7'h3c, 32'h0}, {1'b0, 7'h3d, 32'h0},
    {1'b1, 7'h39, 32'h100}, {1'b0, 7'h39, 32'h100}, {1'b1, 7'h3d, 32'h1111_2222},
    {1'b0, 7'h3d, 32'h1111_2222}, {1'b1, 7'h20, 32'hffff_ffff}, {1'b0, 7'h20, 32'h0}};
  sbx_sys_bus_access sbx_sys_bus_access_i (.clk(clk), .rst_b(rst_b), .dmi_req(req), .dmi_rsp_valid(rsp_v),
    .dmi_rdata(rdata), .read_on_addr(roa), .read_on_data(rod), .auto_increment(ainc), .access_size(size),
    .error_wr(ewr), .error_wdata(ewd), .busy_error_clr(bclr), .bus_busy(busy), .busy_error(berr_busy),
    .bus_error(berr), .bus_req(bus_req), .bus_ready(bus_ready), .bus_rsp(bus_rsp));
  sbx_bus_model sbx_bus_model_i (.clk(clk), .rst_b(rst_b), .slow(slow), .fail(fail), .bus_req(bus_req),
    .bus_ready(bus_ready), .bus_rsp(bus_rsp), .last_req(last_req), .n_acc(n_acc));
  // free-running core clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // one debugger access; answer lands one cycle after the request
  task dmi(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(negedge clk);
    req = {1'b1, w, a, d};
    @(negedge clk);
    req = '0;
    r = rdata;
    `CHK("rsp_valid", 1'b1, rsp_v)
  endtask
  // bounded wait for the master to go idle
  task idle;
    for (k = 0; k < 40 && busy !== 1'b0; k++) @(negedge clk);
    `CHK("busy_idle", 1'b0, busy)
  endtask
  task eclr(input logic [2:0] v);
    @(negedge clk);
    ewr = 1'b1;
    ewd = v;
    @(negedge clk);
    ewr = 1'b0;
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    end_of_test;
  end
  // main sequence
  initial
  begin
    {rst_b, roa, rod, ainc, ewr, bclr, slow, fail, ewd, req} = '0;
    size = 3'h3;
    failures = 0;
    n_checks = 0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    for (i = 0; i < 9; i++)
    begin
      dmi(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK("row_rdata", rows[i].d, r)
    end
    // 64-bit write, high word first, slow bus
    {slow, ainc} = 2'b11;
    dmi(1'b1, 7'h3c, 32'h3333_4444);
    `CHK("busy_set", 1'b1, busy)
    idle;
    `CHK("wr_data", 64'h1111_2222_3333_4444, last_req.wdata)
    `CHK("wr_addr", 32'h100, last_req.addr)
    dmi(1'b0, 7'h39, 32'h0);
    `CHK("addr_inc", 32'h108, r)
    dmi(1'b0, 7'h3c, 32'h0);
    `CHK("wr_keeps_lo", 32'h3333_4444, r)
    // accesses while busy are dropped
    dmi(1'b1, 7'h3c, 32'h3333_4444);
    dmi(1'b1, 7'h39, 32'h55);
    `CHK("busy_err_a", 1'b1, berr_busy)
    dmi(1'b0, 7'h3d, 32'h0);
    idle;
    dmi(1'b0, 7'h39, 32'h0);
    `CHK("addr_kept", 32'h110, r)
    `CHK("one_acc", 2, n_acc)
    dmi(1'b1, 7'h3c, 32'h0);
    `CHK("no_launch", 1'b0, busy)
    @(negedge clk) bclr = 1'b1;
    @(negedge clk) bclr = 1'b0;
    `CHK("busy_err_clr", 1'b0, berr_busy)
    // read on address write, then read on data read
    {slow, ainc, roa} = 3'b001;
    dmi(1'b1, 7'h39, 32'h200);
    idle;
    dmi(1'b0, 7'h3c, 32'h0);
    `CHK("rd_lo", 32'h200, r)
    dmi(1'b0, 7'h3d, 32'h0);
    `CHK("rd_hi", ~32'h200, r)
    {roa, rod} = 2'b01;
    dmi(1'b1, 7'h39, 32'h300);
    dmi(1'b0, 7'h3c, 32'h0);
    `CHK("rod_old", 32'h200, r)
    idle;
    dmi(1'b0, 7'h3d, 32'h0);
    `CHK("rod_new", ~32'h300, r)
    // bus error blocks launches until cleared with all ones
    {roa, rod, fail} = 3'b101;
    dmi(1'b1, 7'h39, 32'h400);
    idle;
    `CHK("err_bad", 3'h2, berr)
    fail = 1'b0;
    i = n_acc;
    dmi(1'b1, 7'h39, 32'h408);
    `CHK("err_block_busy", 1'b0, busy)
    repeat (4) @(negedge clk);
    `CHK("err_block", i, n_acc)
    eclr(3'h3);
    `CHK("err_keep", 3'h2, berr)
    eclr(3'h7);
    `CHK("err_clr", 3'h0, berr)
    // every legal size, with increment
    ainc = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      size = i[2:0];
      dmi(1'b1, 7'h39, 32'h800);
      idle;
      `CHK("size", i[2:0], last_req.size)
      dmi(1'b0, 7'h39, 32'h0);
      `CHK("inc_size", 32'h800 + (32'h1 << i), r)
    end
    // unsupported size and misalignment
    size = 3'h5;
    dmi(1'b1, 7'h39, 32'h900);
    @(negedge clk);
    `CHK("err_size", 3'h4, berr)
    eclr(3'h7);
    size = 3'h2;
    dmi(1'b1, 7'h39, 32'h901);
    @(negedge clk);
    `CHK("err_align", 3'h3, berr)
    `CHK("no_acc", 9, n_acc)
    // reset in mid-run clears the sticky error and the address
    @(negedge clk) rst_b = 1'b0;
    @(negedge clk) rst_b = 1'b1;
    `CHK("rst_err", 3'h0, berr)
    dmi(1'b0, 7'h39, 32'h0);
    `CHK("rst_addr", 32'h0, r)
    end_of_test;
  end
endmodule
